// ===== src/lmr_params.svh
// Register indices, field positions and reset values of the line monitor readout.
// Assumes byte address = 4 x register index on a 32-bit register bus.
`ifndef LMR_PARAMS_SVH
`define LMR_PARAMS_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define LMR_IDX_LOOP     8'h4f
`define LMR_IDX_TIP      8'h50
`define LMR_IDX_RING     8'h51
`define LMR_IDX_BAT_A    8'h52
`define LMR_IDX_BAT_B    8'h53
`define LMR_IDX_Q1       8'h54
`define LMR_IDX_CFG      8'h60
`define LMR_NUM_MON      6

// ****************************************************************
// Fields and limits
// ****************************************************************
`define LMR_LOOP_POL_BIT 6
`define LMR_LOOP_MAG_MAX 8'h3f
`define LMR_CODE_MAX     8'hff
`define LMR_CFG_EN_BIT   0
`define LMR_CFG_OFF_LSB  8
`define LMR_MON_RESET    8'h00
`define LMR_CFG_RESET    9'h000

// ****************************************************************
// Bus responses
// ****************************************************************
`define LMR_RESP_OKAY    2'b00
`define LMR_RESP_SLVERR  2'b10

`endif

// ===== src/lmr_pkg.sv
// Types shared by the line monitor readout modules.
// Assumes lmr_params.svh is on the include path.
`default_nettype none

package lmr_pkg;

  typedef enum logic [2:0] {
    LMR_CH_LOOP  = 3'b000,
    LMR_CH_TIP   = 3'b001,
    LMR_CH_RING  = 3'b010,
    LMR_CH_BAT_A = 3'b011,
    LMR_CH_BAT_B = 3'b100,
    LMR_CH_Q1    = 3'b101
  } lmr_chan_t;

  typedef enum logic [0:0] {
    LMR_W_IDLE = 1'b0,
    LMR_W_RESP = 1'b1
  } lmr_wr_st_t;

  typedef enum logic [0:0] {
    LMR_R_IDLE = 1'b0,
    LMR_R_DATA = 1'b1
  } lmr_rd_st_t;

endpackage

`default_nettype wire

// ===== src/lmr_smp_if.sv
// Carrier between sample source, formatter and monitor bank.
// Assumes one clock; all signals are synchronous to it.
`timescale 1ns/1ps
`default_nettype none

interface lmr_smp_if #(parameter int RAW_W = 12);
  logic             smp_valid;
  logic [2:0]       smp_chan;
  logic [RAW_W-1:0] smp_raw;
  logic             bias_en;
  logic [7:0]       bias_off;
  logic             code_valid;
  logic [2:0]       code_chan;
  logic [7:0]       code;

  modport src  (output smp_valid, smp_chan, smp_raw, bias_en, bias_off);
  modport fmt  (input smp_valid, smp_chan, smp_raw, bias_en, bias_off,
                output code_valid, code_chan, code);
  modport bank (input code_valid, code_chan, code);
endinterface

`default_nettype wire

// ===== src/lmr_fmt.sv
// Formats one signed converter result per strobe into a monitor code.
// Assumes raw values are in units of the target register's step.
`timescale 1ns/1ps
`default_nettype none

`include "lmr_params.svh"

module lmr_fmt #(
  parameter int RAW_W = 12
) (
  input  wire logic clk,       // System clock
  input  wire logic rst_b,     // Async reset, active low
  lmr_smp_if.fmt    smp        // Samples in, codes out
);
  import lmr_pkg::*;

  logic             cv_q, cv_d;
  logic [2:0]       ch_q, ch_d;
  logic [7:0]       code_q, code_d;

  always_comb begin
    logic [RAW_W-1:0] mag;
    logic [RAW_W-1:0] pos;
    logic [RAW_W-1:0] off;
    mag = smp.smp_raw[RAW_W-1] ? RAW_W'(-smp.smp_raw) : smp.smp_raw;
    pos = smp.smp_raw[RAW_W-1] ? '0 : smp.smp_raw;
    off = RAW_W'(smp.bias_off);
    cv_d = 1'b0;
    ch_d = ch_q;
    code_d = code_q;
    if (smp.smp_valid) begin
      ch_d = smp.smp_chan;
      cv_d = 1'b1;
      case (lmr_chan_t'(smp.smp_chan))
        LMR_CH_LOOP: begin
          code_d = (mag > RAW_W'(`LMR_LOOP_MAG_MAX)) ? `LMR_LOOP_MAG_MAX : {2'b00, mag[5:0]};
          code_d[`LMR_LOOP_POL_BIT] = smp.smp_raw[RAW_W-1];
          code_d[7] = 1'b0;
        end
        LMR_CH_TIP, LMR_CH_RING, LMR_CH_BAT_A, LMR_CH_BAT_B: begin
          code_d = (pos > RAW_W'(`LMR_CODE_MAX)) ? `LMR_CODE_MAX : pos[7:0];
        end
        LMR_CH_Q1: begin
          if (smp.bias_en) begin
            pos = (pos > off) ? RAW_W'(pos - off) : '0;
          end
          code_d = (pos > RAW_W'(`LMR_CODE_MAX)) ? `LMR_CODE_MAX : pos[7:0];
        end
        default: begin
          cv_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cv_q   <= 1'b0;
      ch_q   <= 3'b000;
      code_q <= `LMR_MON_RESET;
    end else begin
      cv_q   <= cv_d;
      ch_q   <= ch_d;
      code_q <= code_d;
    end
  end

  assign smp.code_valid = cv_q;
  assign smp.code_chan  = ch_q;
  assign smp.code       = code_q;
endmodule

`default_nettype wire

// ===== src/lmr_bank.sv
// Holds the six monitor registers; each keeps its latest completed code.
// Assumes codes arrive from lmr_fmt one per strobe.
`timescale 1ns/1ps
`default_nettype none

`include "lmr_params.svh"

module lmr_bank (
  input  wire logic        clk,      // System clock
  input  wire logic        rst_b,    // Async reset, active low
  lmr_smp_if.bank          smp,      // Formatted codes
  output var  logic [47:0] mon_flat  // Monitor registers, loop in low byte
);
  import lmr_pkg::*;

  for (genvar i = 0; i < `LMR_NUM_MON; i++) begin : g_mon
    logic [7:0] mon_q, mon_d;
    always_comb begin
      mon_d = mon_q;
      if (smp.code_valid && (smp.code_chan == 3'(i))) begin
        mon_d = smp.code;
      end
    end
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        mon_q <= `LMR_MON_RESET;
      end else begin
        mon_q <= mon_d;
      end
    end
    assign mon_flat[8*i +: 8] = mon_q;
  end
endmodule

`default_nettype wire

// ===== src/lmr_top.sv
// Line monitor readout: AXI4-Lite slave over the read-only line monitors.
// Assumes converter results arrive synchronous to clk, one per strobe.
`timescale 1ns/1ps
`default_nettype none

`include "lmr_params.svh"

module lmr_top #(
  parameter int ADDR_W = 10,
  parameter int RAW_W  = 12
) (
  input  wire logic                clk,            // System clock, 50 MHz
  input  wire logic                rst_b,          // Async reset, active low
  // Converter results
  input  wire logic                conv_valid,     // One-cycle result strobe
  input  wire logic [2:0]          conv_chan,      // Quantity of the result
  input  wire logic [RAW_W-1:0]    conv_raw,       // Signed result in code steps
  // AXI4-Lite write address
  input  wire logic                s_axi_awvalid,  // Write address valid
  output var  logic                s_axi_awready,  // Write address ready
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,   // Write byte address
  input  wire logic [2:0]          s_axi_awprot,   // Protection, unused
  // AXI4-Lite write data
  input  wire logic                s_axi_wvalid,   // Write data valid
  output var  logic                s_axi_wready,   // Write data ready
  input  wire logic [31:0]         s_axi_wdata,    // Write data
  input  wire logic [3:0]          s_axi_wstrb,    // Byte enables
  // AXI4-Lite write response
  output var  logic                s_axi_bvalid,   // Write response valid
  input  wire logic                s_axi_bready,   // Write response ready
  output var  logic [1:0]          s_axi_bresp,    // Write response code
  // AXI4-Lite read address
  input  wire logic                s_axi_arvalid,  // Read address valid
  output var  logic                s_axi_arready,  // Read address ready
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,   // Read byte address
  input  wire logic [2:0]          s_axi_arprot,   // Protection, unused
  // AXI4-Lite read data
  output var  logic                s_axi_rvalid,   // Read data valid
  input  wire logic                s_axi_rready,   // Read data ready
  output var  logic [31:0]         s_axi_rdata,    // Read data
  output var  logic [1:0]          s_axi_rresp     // Read response code
);
  import lmr_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_chk_addr
    $error("lmr_top: ADDR_W must lie between 10 and 32");
  end
  if (RAW_W < 9 || RAW_W > 31) begin : g_chk_raw
    $error("lmr_top: RAW_W must lie between 9 and 31");
  end

  localparam int IDX_W = ADDR_W - 2;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  lmr_wr_st_t        wst_q, wst_d;
  logic              aw_got_q, aw_got_d;
  logic              w_got_q, w_got_d;
  logic [IDX_W-1:0]  widx_q, widx_d;
  logic [31:0]       wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              awready_q, awready_d;
  logic              wready_q, wready_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              bias_en_q, bias_en_d;
  logic [7:0]        bias_off_q, bias_off_d;

  lmr_rd_st_t        rst_q, rst_d;
  logic              arready_q, arready_d;
  logic              rvalid_q, rvalid_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [1:0]        rresp_q, rresp_d;

  logic [47:0]       mon_flat;
  logic [IDX_W-1:0]  ridx;

  lmr_smp_if #(.RAW_W(RAW_W)) smp ();

  // ****************************************************************
  // Index decode helpers
  // ****************************************************************
  function automatic logic is_mon(input logic [IDX_W-1:0] idx);
    is_mon = (idx >= IDX_W'(`LMR_IDX_LOOP)) && (idx <= IDX_W'(`LMR_IDX_Q1));
  endfunction

  function automatic logic is_cfg(input logic [IDX_W-1:0] idx);
    is_cfg = (idx == IDX_W'(`LMR_IDX_CFG));
  endfunction

  // ****************************************************************
  // Write channel: address and data in either order, then response
  // ****************************************************************
  always_comb begin
    wst_d      = wst_q;
    aw_got_d   = aw_got_q;
    w_got_d    = w_got_q;
    widx_d     = widx_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    bias_en_d  = bias_en_q;
    bias_off_d = bias_off_q;
    case (wst_q)
      LMR_W_IDLE: begin
        if (s_axi_awvalid && awready_q) begin
          aw_got_d = 1'b1;
          widx_d   = s_axi_awaddr[ADDR_W-1:2];
        end
        if (s_axi_wvalid && wready_q) begin
          w_got_d = 1'b1;
          wdata_d = s_axi_wdata;
          wstrb_d = s_axi_wstrb;
        end
        if (aw_got_d && w_got_d) begin
          aw_got_d = 1'b0;
          w_got_d  = 1'b0;
          bvalid_d = 1'b1;
          wst_d    = LMR_W_RESP;
          if (is_cfg(widx_d)) begin
            bresp_d = `LMR_RESP_OKAY;
            if (wstrb_d[0]) begin
              bias_en_d = wdata_d[`LMR_CFG_EN_BIT];
            end
            if (wstrb_d[1]) begin
              bias_off_d = wdata_d[`LMR_CFG_OFF_LSB +: 8];
            end
          end else if (is_mon(widx_d)) begin
            bresp_d = `LMR_RESP_OKAY;
          end else begin
            bresp_d = `LMR_RESP_SLVERR;
          end
        end
      end
      LMR_W_RESP: begin
        if (s_axi_bready) begin
          bvalid_d = 1'b0;
          wst_d    = LMR_W_IDLE;
        end
      end
      default: begin
        wst_d    = LMR_W_IDLE;
        bvalid_d = 1'b0;
      end
    endcase
    awready_d = (wst_d == LMR_W_IDLE) && !aw_got_d;
    wready_d  = (wst_d == LMR_W_IDLE) && !w_got_d;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wst_q      <= LMR_W_IDLE;
      aw_got_q   <= 1'b0;
      w_got_q    <= 1'b0;
      widx_q     <= '0;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= `LMR_RESP_OKAY;
      bias_en_q  <= 1'(`LMR_CFG_RESET);
      bias_off_q <= 8'(`LMR_CFG_RESET >> 1);
    end else begin
      wst_q      <= wst_d;
      aw_got_q   <= aw_got_d;
      w_got_q    <= w_got_d;
      widx_q     <= widx_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      bias_en_q  <= bias_en_d;
      bias_off_q <= bias_off_d;
    end
  end

  // ****************************************************************
  // Read channel: data one cycle after the address is taken
  // ****************************************************************
  assign ridx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    logic [IDX_W-1:0] sel;
    sel       = IDX_W'(ridx - IDX_W'(`LMR_IDX_LOOP));
    rst_d     = rst_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    case (rst_q)
      LMR_R_IDLE: begin
        arready_d = 1'b1;
        if (s_axi_arvalid && arready_q) begin
          arready_d = 1'b0;
          rvalid_d  = 1'b1;
          rst_d     = LMR_R_DATA;
          rresp_d   = `LMR_RESP_OKAY;
          rdata_d   = 32'h0000_0000;
          if (is_mon(ridx)) begin
            rdata_d[7:0] = mon_flat[8*sel[2:0] +: 8];
          end else if (is_cfg(ridx)) begin
            rdata_d[`LMR_CFG_EN_BIT]       = bias_en_q;
            rdata_d[`LMR_CFG_OFF_LSB +: 8] = bias_off_q;
          end else begin
            rresp_d = `LMR_RESP_SLVERR;
          end
        end
      end
      LMR_R_DATA: begin
        if (s_axi_rready) begin
          rvalid_d  = 1'b0;
          arready_d = 1'b1;
          rst_d     = LMR_R_IDLE;
        end
      end
      default: begin
        rst_d     = LMR_R_IDLE;
        rvalid_d  = 1'b0;
        arready_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q     <= LMR_R_IDLE;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `LMR_RESP_OKAY;
    end else begin
      rst_q     <= rst_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ****************************************************************
  // Sample path: formatter then monitor bank
  // ****************************************************************
  assign smp.smp_valid = conv_valid;
  assign smp.smp_chan  = conv_chan;
  assign smp.smp_raw   = conv_raw;
  assign smp.bias_en   = bias_en_q;
  assign smp.bias_off  = bias_off_q;

  lmr_fmt #(
    .RAW_W (RAW_W)
  ) u_fmt (
    .clk   (clk),
    .rst_b (rst_b),
    .smp   (smp)
  );

  lmr_bank u_bank (
    .clk      (clk),
    .rst_b    (rst_b),
    .smp      (smp),
    .mon_flat (mon_flat)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule

`default_nettype wire

// ===== tb/lmr_chk.sv
// Bus-side checker of the line monitor readout.
// Assumes it is bound onto lmr_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

`include "lmr_params.svh"

module lmr_chk #(
  parameter int ADDR_W = 10
) (
  input wire logic              clk,           // Clock
  input wire logic              rst_b,         // Reset
  input wire logic              s_axi_awvalid, // Aw valid
  input wire logic              s_axi_awready, // Aw ready
  input wire logic              s_axi_wvalid,  // W valid
  input wire logic              s_axi_wready,  // W ready
  input wire logic              s_axi_bvalid,  // B valid
  input wire logic              s_axi_bready,  // B ready
  input wire logic [1:0]        s_axi_bresp,   // B code
  input wire logic              s_axi_arvalid, // Ar valid
  input wire logic              s_axi_arready, // Ar ready
  input wire logic [ADDR_W-1:0] s_axi_araddr,  // Ar address
  input wire logic              s_axi_rvalid,  // R valid
  input wire logic              s_axi_rready,  // R ready
  input wire logic [31:0]       s_axi_rdata,   // R data
  input wire logic [1:0]        s_axi_rresp    // R code
);
  // ****
  // Index of the read under way
  // ****
  logic [ADDR_W-3:0] idx_q;
  logic              mon_s;
  logic              unm_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_q <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      idx_q <= s_axi_araddr[ADDR_W-1:2];
    end
  end

  assign mon_s = idx_q >= `LMR_IDX_LOOP && idx_q <= `LMR_IDX_Q1;
  assign unm_s = !mon_s && idx_q != `LMR_IDX_CFG;

  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer not held");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  pol_top_a: assert property (s_axi_rvalid && idx_q == `LMR_IDX_LOOP |-> !s_axi_rdata[7])
    else $error("loop bit 7 set");
  mon_rd_a: assert property (s_axi_rvalid && mon_s |->
    s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == `LMR_RESP_OKAY)
    else $error("monitor read malformed");
  unmap_rd_a: assert property (s_axi_rvalid && unm_s |->
    s_axi_rdata == 32'h0 && s_axi_rresp == `LMR_RESP_SLVERR)
    else $error("unmapped read not refused");
  wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid)
    else $error("write answer missing");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");

  cover property (s_axi_rvalid && s_axi_rready && mon_s);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && unm_s);
endmodule

`default_nettype wire

// ===== tb/line_monitor_readout_tb.sv
// Self-checking bench of the line monitor readout.
// Assumes lmr_top with ADDR_W 10 and RAW_W 12.
`timescale 1ns/1ps
`default_nettype none

`include "lmr_params.svh"

module line_monitor_readout_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        conv_valid = 1'b0;
  logic [2:0]  conv_chan = 3'h0;
  logic [11:0] conv_raw = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [9:0]  s_axi_awaddr = 10'h000;
  logic [9:0]  s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [11:0] v;
  int          failures = 0;
  int          n_tests = 0;
  int          mon [6];
  int          cfg_en, cfg_off;
  int          edge_v [11] = '{0, 1, -1, 63, 64, -63, -64, 255, 256, 2047, -2048};

  always #10 clk = ~clk;

  lmr_top uut (
    .clk(clk), .rst_b(rst_b), .conv_valid(conv_valid), .conv_chan(conv_chan),
    .conv_raw(conv_raw), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
  );

  // ****
  // Model and checks
  // ****
  task final_report;
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp_d(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_r(input logic [1:0] g, input logic [1:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t resp %h exp %h", $time, g, e);
    end
  endtask

  function automatic int fmtc(int c, int x);
    int m;
    m = x < 0 ? -x : x;
    if (c == 0) return (x < 0 ? 64 : 0) + (m > 63 ? 63 : m);
    if (x < 0) return 0;
    if (c == 5 && cfg_en != 0) x = x > cfg_off ? x - cfg_off : 0;
    return x > 255 ? 255 : x;
  endfunction

  // ****
  // Bus and sample drivers
  // ****
  task automatic rd(input logic [7:0] i, output logic [31:0] dr, output logic [1:0] rs);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= {i, 2'b00};
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    dr = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] dw, input logic [3:0] st,
                    output logic [1:0] rs);
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= dw;
    s_axi_wstrb <= st;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready && !a) begin
        a = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(a && w));
    do @(posedge clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic smp(int c, int x);
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_chan <= c[2:0];
    conv_raw <= x[11:0];
    if (c < 6) mon[c] = fmtc(c, x);
  endtask

  task idle;
    @(posedge clk);
    conv_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task chk_all;
    for (int i = 0; i < 6; i++) begin
      rd(8'h4f + 8'(i), d, r);
      cmp_d(d, 32'(mon[i]));
      cmp_r(r, `LMR_RESP_OKAY);
    end
  endtask

  task do_reset;
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    foreach (mon[i]) mon[i] = 0;
    cfg_en = 0;
    cfg_off = 0;
  endtask

  // ****
  // Scenarios
  // ****
  initial begin
    #1000000;
    failures++;
    final_report();
  end

  initial begin
    void'($urandom(99006));
    do_reset();
    chk_all();
    rd(8'h60, d, r);
    cmp_d(d, 32'h0);
    rd(8'h55, d, r);
    cmp_r(r, `LMR_RESP_SLVERR);
    // Boundary codes on every channel, back to back
    foreach (edge_v[k]) begin
      for (int c = 0; c < 8; c++) smp(c, edge_v[k]);
      idle();
      chk_all();
    end
    // Writes to the monitors change nothing
    for (int i = 0; i < 6; i++) begin
      wr(8'h4f + 8'(i), 32'hffffffff, 4'hf, r);
      cmp_r(r, `LMR_RESP_OKAY);
    end
    chk_all();
    wr(8'h70, 32'h1, 4'hf, r);
    cmp_r(r, `LMR_RESP_SLVERR);
    // Offset removed only while enabled; lane 1 alone holds the offset
    cfg_off = $urandom_range(1, 200);
    for (int e = 1; e >= 0; e--) begin
      wr(8'h60, {16'h0, e ? cfg_off[7:0] : 8'h5a, 7'h0, e[0]}, e ? 4'h3 : 4'h1, r);
      cfg_en = e;
      rd(8'h60, d, r);
      cmp_d(d, {16'h0, cfg_off[7:0], 7'h0, e[0]});
      repeat (20) begin
        smp(5, $urandom_range(0, 511));
        idle();
        rd(8'h54, d, r);
        cmp_d(d, 32'(mon[5]));
      end
    end
    // Random traffic
    repeat (60) begin
      v = 12'($urandom);
      smp($urandom_range(0, 7), $signed(v));
      if ($urandom_range(0, 3) == 0) begin
        idle();
        chk_all();
      end
    end
    idle();
    chk_all();
    do_reset();
    chk_all();
    final_report();
  end
endmodule

bind lmr_top lmr_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
);

`default_nettype wire
